// ===== src/wle_pkg.sv
// Purpose: shared constants and types for the word load execution block
// Assumes: 32-bit registers, 32 general registers, byte-addressed storage
// Notes: register map for the AXI4-Lite command window lives here
//
// What this block does
// - string load address is index plus base, base zero when field zero
// - string load byte count comes from the transfer byte count field
// - four bytes per register, lowest address into most significant byte
// - bits right of the last loaded byte in last register are zero
// - registers fill from target upward, wrap from 31 to 0
// - zero byte count makes the string load a no-operation
// - storage, translation or compare fault ends string load as a no-op; registers loaded before it keep their data
// - bit 31 set on indexed forms may leave condition field zero undefined
// - multiple and string loads restart from the beginning after interrupt
// - reserving load reads indexed word into target and sets reservation
// - only reserving load sets reservation; conditional store always clears it
// - reserving load issues one word request at any alignment, never split
// - byte reversed load returns the word with byte order reversed
// - displacement is the full 32-bit DISP register value, base zero when field zero
// - word loads place the full 32-bit word in the target
// - update forms write the effective address back into the base register
package wle_pkg;
  localparam int unsigned WLE_XLEN = 32;
  localparam int unsigned WLE_NREG = 32;
  localparam int unsigned WLE_RIDX = 5;
  localparam int unsigned WLE_CNT_W = 7;
  localparam int unsigned WLE_BYTES_PER_REG = 4;

  // register byte addresses
  localparam logic [7:0] WLE_A_CMD = 8'h00;
  localparam logic [7:0] WLE_A_DISP = 8'h04;
  localparam logic [7:0] WLE_A_CNT = 8'h08;
  localparam logic [7:0] WLE_A_STAT = 8'h0c;
  localparam logic [7:0] WLE_A_GSEL = 8'h10;
  localparam logic [7:0] WLE_A_GDAT = 8'h14;
  localparam logic [7:0] WLE_A_FAULT = 8'h18;

  // cmd register fields, and the byte count field of the cnt register
  localparam int unsigned WLE_F_OP = 0;
  localparam int unsigned WLE_F_TGT = 4;
  localparam int unsigned WLE_F_BASE = 9;
  localparam int unsigned WLE_F_IDX = 14;
  localparam int unsigned WLE_F_B31 = 19;
  localparam int unsigned WLE_F_XTBC = 0;

  // status register fields
  localparam int unsigned WLE_S_BUSY = 0;
  localparam int unsigned WLE_S_RSV = 1;
  localparam int unsigned WLE_S_NOOP = 2;
  localparam int unsigned WLE_S_CR0U = 3;

  localparam logic [1:0] WLE_RESP_OK = 2'b00;
  localparam logic [1:0] WLE_RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    WLE_OP_NONE = 4'h0,
    WLE_OP_STRX = 4'h1,
    WLE_OP_LWARX = 4'h2,
    WLE_OP_LDBR = 4'h3,
    WLE_OP_LDD = 4'h4,
    WLE_OP_LDDU = 4'h5,
    WLE_OP_LDXU = 4'h6,
    WLE_OP_LDX = 4'h7,
    WLE_OP_STCX = 4'h8
  } wle_op_e;

  // one bit changes along idle, addr, wait, done
  typedef enum logic [2:0] {
    WLE_ST_IDLE = 3'b000,
    WLE_ST_ADDR = 3'b001,
    WLE_ST_WAIT = 3'b011,
    WLE_ST_DONE = 3'b010,
    WLE_ST_REQ = 3'b110
  } wle_state_e;

  typedef struct packed {
    logic valid;
    logic [WLE_XLEN-1:0] addr;
  } wle_mreq_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [WLE_XLEN-1:0] data;
  } wle_mrsp_s;

  typedef struct packed {
    logic we;
    logic [WLE_RIDX-1:0] waddr;
    logic [WLE_XLEN-1:0] wdata;
  } wle_gwr_s;
endpackage

// ===== src/wle_regfile.sv
// Purpose: general register array with two read ports and one write port
// Assumes: single clock, synchronous reset clears nothing but read registers
// Notes: read data come out of registers, one cycle after the address
`timescale 1ns/10ps
module wle_regfile #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire wle_pkg::wle_gwr_s wr,
  input wire logic [$clog2(DEPTH)-1:0] raddr_a,
  input wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b
);
  import wle_pkg::*;

  initial begin
    if (DEPTH < 2 || WIDTH < 8) $error("wle_regfile: bad geometry");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (ce && wr.we) begin
      mem[wr.waddr] <= wr.wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else if (ce) begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule

// ===== src/wle_pack.sv
// Purpose: places string-load bytes into a register word
// Assumes: byte lane 0 is the most significant byte
// Notes: combinational; lanes at or past the count come out zero
`timescale 1ns/10ps
module wle_pack (
  input wire logic [31:0] mem_word,
  input wire logic [2:0] nbytes,
  output logic [31:0] packed_word
);
  import wle_pkg::*;

  always_comb begin
    packed_word = '0;
    for (int i = 0; i < WLE_BYTES_PER_REG; i++) begin
      if (i < int'(nbytes)) begin
        packed_word[31-8*i -: 8] = mem_word[31-8*i -: 8];
      end
    end
    // lanes beyond the count stay zero
  end
endmodule

// ===== src/wle_top.sv
// Purpose: executes word loads, string load and reservation updates
// Assumes: storage answers each word request with one response, any latency
// Notes: commands issued over AXI4-Lite; storage port is request/response
`timescale 1ns/10ps
module wle_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // storage load path
  output wle_pkg::wle_mreq_s mreq,
  input wire wle_pkg::wle_mrsp_s mrsp,
  output logic reservation,
  output logic cond_undef
);
  import wle_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  wle_state_e st, next_st;
  wle_op_e op, next_op;
  logic [WLE_RIDX-1:0] tgt, next_tgt, bsel, next_bsel, isel, next_isel, cur, next_cur;
  logic [WLE_XLEN-1:0] ea, next_ea, cmd_disp, next_cmd_disp;
  logic [WLE_CNT_W-1:0] left, next_left, cnt_reg, next_cnt_reg;
  logic rsv, next_rsv, noop, next_noop, cr0u, next_cr0u, upd, next_upd;
  logic [WLE_RIDX-1:0] gsel, next_gsel;
  logic [WLE_XLEN-1:0] fault_in, next_fault_in;
  wle_mreq_s next_mreq;
  wle_gwr_s gwr;
  logic [WLE_XLEN-1:0] rd_a, rd_b, base, pk;
  logic [2:0] nb;
  logic start;
  logic [31:0] cmd_w;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_h, next_aw_h, w_h, next_w_h, next_awready, next_wready;
  logic [7:0] aw_a, next_aw_a;
  logic [31:0] w_d, next_w_d;
  logic next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_go;

  always_comb begin
    next_aw_h = aw_h;
    next_w_h = w_h;
    next_aw_a = aw_a;
    next_w_d = w_d;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    wr_go = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_h = 1'b1;
      next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_h = 1'b1;
      next_w_d = s_axi_wdata;
    end
    if (aw_h && w_h && !s_axi_bvalid) begin
      wr_go = 1'b1;
      next_aw_h = 1'b0;
      next_w_h = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = WLE_RESP_OK;
      if (aw_a > WLE_A_FAULT || aw_a[1:0] != 2'b00) next_bresp = WLE_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_h && !next_bvalid;
    next_wready = !next_w_h && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = WLE_RESP_OK;
      case (s_axi_araddr)
        WLE_A_CMD: next_rdata = {28'h000_0000, op};
        WLE_A_DISP: next_rdata = cmd_disp;
        WLE_A_CNT: next_rdata = {25'h000_0000, cnt_reg};
        WLE_A_STAT: next_rdata = {28'h000_0000, cr0u, noop, rsv, st != WLE_ST_IDLE};
        WLE_A_GSEL: next_rdata = {27'h000_0000, gsel};
        WLE_A_GDAT: next_rdata = rd_b;
        WLE_A_FAULT: next_rdata = fault_in;
        default: begin
          next_rdata = '0;
          next_rresp = WLE_RESP_SLVERR;
        end
      endcase
    end else if (!next_rvalid && s_axi_arvalid && !s_axi_arready) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= '0;
      w_d <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WLE_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= WLE_RESP_OK;
      s_axi_rdata <= '0;
    end else if (ce) begin
      aw_h <= next_aw_h;
      w_h <= next_w_h;
      aw_a <= next_aw_a;
      w_d <= next_w_d;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // register file and packing
  // ----------------------------------------
  wle_regfile #(.DEPTH(WLE_NREG), .WIDTH(WLE_XLEN)) u_gpr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr(gwr),
    .raddr_a(st == WLE_ST_IDLE ? next_bsel : bsel),
    .raddr_b(st == WLE_ST_IDLE ? (start ? next_isel : gsel) : isel),
    .rdata_a(rd_a),
    .rdata_b(rd_b)
  );

  assign nb = (left >= WLE_CNT_W'(WLE_BYTES_PER_REG)) ? 3'd4 : left[2:0];

  wle_pack u_pack (
    .mem_word(mrsp.data),
    .nbytes(nb),
    .packed_word(pk)
  );

  // ----------------------------------------
  // execution
  // ----------------------------------------
  assign cmd_w = w_d;
  assign start = wr_go && aw_a == WLE_A_CMD && st == WLE_ST_IDLE;
  assign base = (bsel == '0) ? '0 : rd_a;

  always_comb begin
    next_st = st;
    next_op = op;
    next_tgt = tgt;
    next_bsel = bsel;
    next_isel = isel;
    next_cur = cur;
    next_ea = ea;
    next_left = left;
    next_rsv = rsv;
    next_noop = noop;
    next_cr0u = cr0u;
    next_upd = 1'b0;
    next_cmd_disp = cmd_disp;
    next_cnt_reg = cnt_reg;
    next_gsel = gsel;
    next_fault_in = fault_in;
    next_mreq = mreq;
    gwr = '0;
    if (wr_go && aw_a == WLE_A_DISP) next_cmd_disp = w_d;
    if (wr_go && aw_a == WLE_A_CNT) next_cnt_reg = w_d[WLE_F_XTBC +: WLE_CNT_W];
    if (wr_go && aw_a == WLE_A_GSEL) next_gsel = w_d[WLE_RIDX-1:0];
    case (st)
      WLE_ST_IDLE: begin
        if (start) begin
          next_op = wle_op_e'(cmd_w[WLE_F_OP +: 4]);
          next_tgt = cmd_w[WLE_F_TGT +: WLE_RIDX];
          next_bsel = cmd_w[WLE_F_BASE +: WLE_RIDX];
          next_isel = cmd_w[WLE_F_IDX +: WLE_RIDX];
          next_cur = next_tgt;
          next_left = cnt_reg;
          next_noop = 1'b0;
          next_cr0u = cmd_w[WLE_F_B31];
          next_st = WLE_ST_ADDR;
          if (next_op == WLE_OP_STCX) begin
            next_rsv = 1'b0;
            next_st = WLE_ST_IDLE;
          end else if (next_op == WLE_OP_NONE || next_op > WLE_OP_STCX) begin
            next_st = WLE_ST_IDLE;
          end
        end
      end
      WLE_ST_ADDR: begin
        case (op)
          WLE_OP_LDD, WLE_OP_LDDU: next_ea = base + cmd_disp;
          default: next_ea = base + rd_b;
        endcase
        if (op == WLE_OP_STRX && left == '0) begin
          next_noop = 1'b1;
          next_st = WLE_ST_IDLE;
        end else begin
          next_mreq.valid = 1'b1;
          next_mreq.addr = next_ea;
          next_st = WLE_ST_WAIT;
        end
      end
      WLE_ST_WAIT: begin
        next_mreq.valid = 1'b0;
        if (mrsp.valid) begin
          next_fault_in = mrsp.fault ? ea : fault_in;
          if (op == WLE_OP_STRX) begin
            if (mrsp.fault) begin
              next_noop = 1'b1;
              next_st = WLE_ST_IDLE;
            end else begin
              gwr.we = 1'b1;
              gwr.waddr = cur;
              gwr.wdata = pk;
              next_cur = cur + 1'b1; // wraps 31 to 0
              next_left = left - WLE_CNT_W'(nb);
              next_ea = ea + 32'h0000_0004;
              if (next_left == '0) begin
                next_st = WLE_ST_IDLE;
              end else begin
                next_mreq.valid = 1'b1;
                next_mreq.addr = next_ea;
              end
            end
          end else if (!mrsp.fault) begin
            gwr.we = 1'b1;
            gwr.waddr = tgt;
            gwr.wdata = (op == WLE_OP_LDBR) ? {mrsp.data[7:0], mrsp.data[15:8],
              mrsp.data[23:16], mrsp.data[31:24]} : mrsp.data;
            if (op == WLE_OP_LWARX) next_rsv = 1'b1;
            next_upd = (op == WLE_OP_LDDU || op == WLE_OP_LDXU);
            next_st = next_upd ? WLE_ST_DONE : WLE_ST_IDLE;
          end else begin
            next_st = WLE_ST_IDLE;
          end
        end
      end
      WLE_ST_DONE: begin
        gwr.we = upd;
        gwr.waddr = bsel;
        gwr.wdata = ea;
        next_st = WLE_ST_IDLE;
      end
      default: next_st = WLE_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= WLE_ST_IDLE;
      op <= WLE_OP_NONE;
      tgt <= '0;
      bsel <= '0;
      isel <= '0;
      cur <= '0;
      ea <= '0;
      left <= '0;
      rsv <= 1'b0;
      noop <= 1'b0;
      cr0u <= 1'b0;
      upd <= 1'b0;
      cmd_disp <= '0;
      cnt_reg <= '0;
      gsel <= '0;
      fault_in <= '0;
      mreq <= '0;
      reservation <= 1'b0;
      cond_undef <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      op <= next_op;
      tgt <= next_tgt;
      bsel <= next_bsel;
      isel <= next_isel;
      cur <= next_cur;
      ea <= next_ea;
      left <= next_left;
      rsv <= next_rsv;
      noop <= next_noop;
      cr0u <= next_cr0u;
      upd <= next_upd;
      cmd_disp <= next_cmd_disp;
      cnt_reg <= next_cnt_reg;
      gsel <= next_gsel;
      fault_in <= next_fault_in;
      mreq <= next_mreq;
      reservation <= next_rsv;
      cond_undef <= next_cr0u;
    end
  end
  // restart after interrupt is reissuing the command from scratch
endmodule

// ===== tb/wle_store_model.sv
// Purpose: storage side of the load path, byte-consistent memory
// Assumes: one request outstanding, answer after lat idle cycles
// Notes: top address nibble f answers with a fault
`timescale 1ns/10ps
module wle_store_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire wle_pkg::wle_mreq_s mreq,
  input wire logic [3:0] lat,
  output wle_pkg::wle_mrsp_s mrsp
);
  import wle_pkg::*;
  logic pend;
  logic [3:0] cnt;
  logic [31:0] addr;
  function automatic logic [7:0] bt(logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [31:0] wd(logic [31:0] a);
    return {bt(a), bt(a + 32'h1), bt(a + 32'h2), bt(a + 32'h3)};
  endfunction
  always @(posedge aclk) begin
    mrsp.valid <= 1'b0;
    mrsp.fault <= 1'b0;
    // released data line toggles
    mrsp.data <= ~mrsp.data;
    if (!aresetn) begin
      pend <= 1'b0;
      mrsp.data <= 32'h0;
    end else if (mreq.valid === 1'b1) begin
      pend <= 1'b1;
      addr <= mreq.addr;
      cnt <= lat;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      mrsp.valid <= 1'b1;
      mrsp.fault <= addr[31:28] == 4'hf;
      mrsp.data <= wd(addr);
    end
  end
endmodule

// ===== tb/wle_top_monitor.sv
// Purpose: port checker for wle_top
// Assumes: single clock, reset active low
// Notes: bound from the testbench file
`timescale 1ns/10ps
module wle_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire wle_pkg::wle_mreq_s mreq,
  input wire wle_pkg::wle_mrsp_s mrsp,
  input wire logic reservation,
  input wire logic cond_undef
);
  import wle_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_held: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken with response pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == WLE_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  a_req_pulse: assert property (mreq.valid |=> !mreq.valid)
    else $error("load request longer than one cycle");
  a_rsv_cause: assert property ($rose(reservation)
    |-> $past(mrsp.valid) || $past(mrsp.valid, 2)) else $error("reservation set without load");
  a_reset_clean: assert property ($rose(aresetn) |-> !reservation && !cond_undef
    && !mreq.valid && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not clear at reset");
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for wle_top
// Assumes: storage model answers every request
// Notes: general registers are loaded through word loads
`timescale 1ns/10ps
module testbench;
  import wle_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, r5, r6, last_ea;
  logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reservation, cond_undef;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  wle_mreq_s mreq;
  wle_mrsp_s mrsp;
  int errors = 0, samples_checked = 0, nreq = 0, n0;
  wle_top wle_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mreq, .mrsp, .reservation, .cond_undef);
  wle_store_model stor_i (.aclk, .aresetn, .mreq, .lat, .mrsp);
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (mreq.valid === 1'b1) begin
      nreq <= nreq + 1;
      last_ea <= mreq.addr;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1) errors++;
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) errors++;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] mk(logic [3:0] op, logic [4:0] t, a, b, logic c);
    return {12'h000, c, b, a, t, op};
  endfunction
  task automatic run(input logic [31:0] c);
    int n;
    axw(WLE_A_CMD, c);
    n = 0;
    do begin
      axr(WLE_A_STAT);
      n++;
    end while (rd[WLE_S_BUSY] !== 1'b0 && n < 50);
    if (rd[WLE_S_BUSY] !== 1'b0) errors++;
  endtask
  task automatic gchk(input logic [4:0] i, input logic [31:0] e);
    axw(WLE_A_GSEL, {27'h0, i});
    axr(WLE_A_GDAT);
    chk(rd, e);
  endtask
  // expected string-load word k for count n
  function automatic logic [31:0] sw(logic [31:0] ea, int k, int n);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 4; i++)
      if (4 * k + i < n) v[31 - 8 * i -: 8] = stor_i.bt(ea + 32'(4 * k + i));
    return v;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(WLE_A_STAT);
    chk(rd, 32'h0);
    chkb(reservation, 1'b0);
    $display("test reset done");
    axw(WLE_A_DISP, 32'h0000_0100);
    run(mk(4, 5, 0, 0, 0));
    r5 = stor_i.wd(32'h0000_0100);
    gchk(5, r5);
    lat <= 4'h5;
    axw(WLE_A_DISP, 32'h0000_0200);
    run(mk(4, 6, 0, 0, 0));
    r6 = stor_i.wd(32'h0000_0200);
    gchk(6, r6);
    axw(WLE_A_DISP, 32'hffff_fff0);
    run(mk(4, 7, 5, 0, 0));
    chk(last_ea, r5 - 32'h10);
    gchk(7, stor_i.wd(r5 - 32'h10));
    axw(WLE_A_DISP, 32'h4);
    run(mk(5, 8, 5, 0, 0));
    gchk(8, stor_i.wd(r5 + 32'h4));
    r5 = r5 + 32'h4;
    gchk(5, r5);
    run(mk(6, 9, 5, 6, 0));
    gchk(9, stor_i.wd(r5 + r6));
    r5 = r5 + r6;
    gchk(5, r5);
    run(mk(7, 10, 0, 6, 1));
    gchk(10, stor_i.wd(r6));
    chkb(cond_undef, 1'b1);
    run(mk(3, 11, 5, 6, 0));
    gchk(11, {<<8{stor_i.wd(r5 + r6)}});
    chkb(cond_undef, 1'b0);
    $display("test word loads done");
    run(mk(2, 12, 0, 6, 0));
    gchk(12, stor_i.wd(r6));
    chkb(reservation, 1'b1);
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    chkb(reservation, 1'b1);
    run(mk(8, 0, 0, 0, 0));
    chkb(reservation, 1'b0);
    chkb(rd[WLE_S_RSV], 1'b0);
    axw(WLE_A_DISP, 32'h0000_0400 - r5);
    run(mk(5, 14, 5, 0, 0));
    r5 = 32'h0000_0400;
    gchk(5, r5);
    run(mk(2, 15, 0, 5, 0));
    gchk(15, stor_i.wd(r5));
    chkb(reservation, 1'b1);
    run(mk(8, 0, 0, 0, 0));
    chkb(reservation, 1'b0);
    $display("test reservation done");
    lat <= 4'h0;
    axw(WLE_A_CNT, 32'h7);
    run(mk(1, 30, 0, 6, 0));
    gchk(30, sw(r6, 0, 7));
    gchk(31, sw(r6, 1, 7));
    axw(WLE_A_CNT, 32'ha);
    n0 = nreq;
    run(mk(1, 31, 5, 6, 0));
    chk(32'(nreq - n0), 32'h3);
    for (int k = 0; k < 3; k++) gchk(5'(31 + k), sw(r5 + r6, k, 10));
    axw(WLE_A_CNT, 32'h0);
    n0 = nreq;
    run(mk(1, 20, 0, 6, 0));
    chk(32'(nreq - n0), 32'h0);
    axw(WLE_A_DISP, 32'h0000_00c0);
    run(mk(4, 13, 0, 0, 0));
    axw(WLE_A_CNT, 32'h8);
    run(mk(1, 30, 0, 13, 0));
    chkb(rd[WLE_S_NOOP], 1'b1);
    axr(WLE_A_FAULT);
    chk(rd, 32'hfcfd_feff);
    gchk(30, sw(r6, 0, 7));
    chkb(reservation, 1'b0);
    $display("test string loads done");
    axr(8'h20);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, WLE_RESP_SLVERR});
    axw(8'h20, 32'h1);
    chk({30'h0, rsp}, {30'h0, WLE_RESP_SLVERR});
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule
bind wle_top wle_top_monitor wle_top_monitor_i (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mreq, .mrsp, .reservation, .cond_undef);
